// *** core/bcc_flow_unit.sv ***
// Program-flow unit: calls, exits, compares, skips and flag branches.
`timescale 1ns/10ps
// ****************************************************************
// Summary of operation
// ****************************************************************
// Summary of operation
// RULE1: Three call forms, 3/3/4 cycles, flags kept.
// RULE2: Equal registers skip next instruction, flags kept.
// RULE3: Compares update five flags in one cycle.
// RULE4: Register bit clear skips next instruction.
// RULE5: Register bit set skips next instruction.
// RULE6: I/O bit clear skips next instruction.
// RULE7: I/O bit set skips next instruction.
// RULE8: Selected status bit set takes relative branch.
// RULE9: Selected status bit clear takes relative branch.
// RULE10: Zero flag set takes relative branch.
// RULE11: Zero flag clear takes relative branch.
// RULE12: Calls push return; exits pop in four.
// RULE13: Taken branch and skipped words add cycles.
module bcc_flow_unit (
  input  wire logic                        clock,
  input  wire logic                        sys_rst,
  input  wire bcc_pkg::bcc_instr_s         instr,
  input  wire logic                        instr_valid,
  output logic                             instr_ready,
  output logic                             retire,
  output logic [bcc_pkg::PC_W-1:0]         pc,
  output logic [bcc_pkg::DATA_W-1:0]       status_flags,
  output bcc_pkg::bcc_stack_s              stack_push,
  output logic                             stack_pop,
  input  wire logic [bcc_pkg::PC_W-1:0]    stack_pop_data,
  input  wire logic [bcc_pkg::BUS_AW-1:0]  bus_addr,
  input  wire logic [bcc_pkg::BUS_DW-1:0]  bus_wdata,
  input  wire logic                        bus_we,
  input  wire logic                        bus_re,
  output logic [bcc_pkg::BUS_DW-1:0]       bus_rdata
);
  import bcc_pkg::*;

  typedef enum logic {
    ST_IDLE,
    ST_EXEC
  } bcc_state_e;

  bcc_state_e           state_q;
  logic [CYC_W-1:0]     cnt_q;
  logic [PC_W-1:0]      pc_q;
  logic [PC_W-1:0]      target_q;
  logic [DATA_W-1:0]    status_register_q;
  logic                 run_q;
  logic                 set_i_q;
  logic                 pop_q;
  logic                 pop_wait_q;
  logic                 retire_q;
  logic [BUS_DW-1:0]    rdata_q;
  bcc_stack_s           push_q;

  logic                 accept;
  logic                 finish;
  logic [CYC_W-1:0]     cycles_d;
  logic [PC_W-1:0]      target_d;
  logic [PC_W-1:0]      ret_addr_d;
  logic [DATA_W-1:0]    status_register_d;
  logic                 push_d;
  logic                 pop_d;
  logic                 set_i_d;
  logic                 skip_d;
  logic                 take_d;
  logic [DATA_W-1:0]    cmp_sub;
  logic [DATA_W-1:0]    cmp_res;
  logic                 cmp_cin;
  logic                 cmp_zero_chain;
  logic                 cmp_en;
  logic [PC_W-1:0]      seq_pc;
  logic [PC_W-1:0]      rel_pc;
  logic [PC_W-1:0]      skip_pc;
  logic [CYC_W-1:0]     skip_cycles;

  // A new instruction is taken only while idle and enabled by software.
  assign instr_ready  = (state_q == ST_IDLE) && run_q;
  assign accept       = instr_ready && instr_valid;
  assign finish       = (state_q == ST_EXEC) && (cnt_q == CYC_ONE);
  assign retire       = retire_q;
  assign pc           = pc_q;
  assign status_flags = status_register_q;
  assign stack_push   = push_q;
  assign stack_pop    = pop_q;
  assign bus_rdata    = rdata_q;

  // ****************************************************************
  // Address arithmetic
  // ****************************************************************
  assign seq_pc  = pc_q + 16'h0001;
  assign rel_pc  = pc_q + instr.k_val + 16'h0001;
  assign skip_pc = instr.next_two_words ? pc_q + 16'h0003
                                        : pc_q + 16'h0002;
  assign skip_cycles = instr.next_two_words ? CYC_SKIP_TWO
                                            : CYC_SKIP_ONE; // RULE13

  // ****************************************************************
  // Compare datapath
  // ****************************************************************
  always_comb begin
    cmp_sub        = instr.rr_val;
    cmp_cin        = 1'b0;
    cmp_zero_chain = 1'b0;
    cmp_en         = 1'b0;
    case (instr.op)
      OP_REGISTER_COMPARE: begin
        cmp_en = 1'b1; // RULE3
      end
      OP_COMPARE_WITH_CARRY: begin
        cmp_en         = 1'b1;
        cmp_cin        = status_register_q[FLAG_C]; // RULE3
        cmp_zero_chain = 1'b1;
      end
      OP_COMPARE_IMMEDIATE: begin
        cmp_en  = 1'b1;
        cmp_sub = instr.imm_val; // RULE3
      end
      default: begin
        cmp_en = 1'b0;
      end
    endcase
  end

  assign cmp_res = instr.rd_val - cmp_sub - {7'h00, cmp_cin};

  // ****************************************************************
  // Per-instruction decision
  // ****************************************************************
  always_comb begin
    cycles_d   = CYC_ONE;
    target_d   = seq_pc;
    ret_addr_d = seq_pc;
    status_register_d     = status_register_q;
    push_d     = 1'b0;
    pop_d      = 1'b0;
    set_i_d    = 1'b0;
    skip_d     = 1'b0;
    take_d     = 1'b0;
    case (instr.op)
      OP_RELATIVE_SUBROUTINE_JUMP: begin
        cycles_d = CYC_REL_CALL; // RULE1
        target_d = rel_pc;
        push_d   = 1'b1; // RULE12
      end
      OP_INDIRECT_SUBROUTINE_JUMP: begin
        cycles_d = CYC_IND_CALL; // RULE1
        target_d = instr.z_ptr;
        push_d   = 1'b1; // RULE12
      end
      OP_DIRECT_SUBROUTINE_JUMP: begin
        cycles_d   = CYC_DIR_CALL; // RULE1
        target_d   = instr.k_val;
        ret_addr_d = pc_q + 16'h0002;
        push_d     = 1'b1; // RULE12
      end
      OP_SUBROUTINE_EXIT: begin
        cycles_d = CYC_EXIT; // RULE12
        pop_d    = 1'b1;
      end
      OP_INTERRUPT_EXIT: begin
        cycles_d = CYC_EXIT; // RULE12
        pop_d    = 1'b1;
        set_i_d  = 1'b1;
      end
      OP_COMPARE_SKIP_EQUAL: begin
        skip_d = (instr.rd_val == instr.rr_val); // RULE2
      end
      OP_SKIP_IF_REGISTER_BIT_CLEAR: begin
        skip_d = ~instr.rr_val[instr.bit_sel]; // RULE4
      end
      OP_SKIP_IF_REGISTER_BIT_SET: begin
        skip_d = instr.rr_val[instr.bit_sel]; // RULE5
      end
      OP_SKIP_IF_IO_BIT_CLEAR: begin
        skip_d = ~instr.io_val[instr.bit_sel]; // RULE6
      end
      OP_SKIP_IF_IO_BIT_SET: begin
        skip_d = instr.io_val[instr.bit_sel]; // RULE7
      end
      OP_BRANCH_ON_FLAG_SET: begin
        take_d = status_register_q[instr.bit_sel]; // RULE8
      end
      OP_BRANCH_ON_FLAG_CLEAR: begin
        take_d = ~status_register_q[instr.bit_sel]; // RULE9
      end
      OP_BRANCH_ON_EQUAL: begin
        take_d = status_register_q[FLAG_Z]; // RULE10
      end
      OP_BRANCH_ON_NOT_EQUAL: begin
        take_d = ~status_register_q[FLAG_Z]; // RULE11
      end
      default: begin
        cycles_d = CYC_ONE;
      end
    endcase
    if (skip_d) begin
      cycles_d = skip_cycles; // RULE13
      target_d = skip_pc;
    end
    if (take_d) begin
      cycles_d = CYC_BR_TAKEN; // RULE13
      target_d = rel_pc;
    end
    if (cmp_en) begin
      status_register_d[FLAG_N] = cmp_res[7]; // RULE3
      status_register_d[FLAG_Z] = (cmp_res == 8'h00) &&
                       (!cmp_zero_chain || status_register_q[FLAG_Z]);
      status_register_d[FLAG_C] = (~instr.rd_val[7] & cmp_sub[7]) |
                       (cmp_sub[7] & cmp_res[7]) |
                       (cmp_res[7] & ~instr.rd_val[7]);
      status_register_d[FLAG_H] = (~instr.rd_val[3] & cmp_sub[3]) |
                       (cmp_sub[3] & cmp_res[3]) |
                       (cmp_res[3] & ~instr.rd_val[3]);
      status_register_d[FLAG_V] = (instr.rd_val[7] & ~cmp_sub[7] & ~cmp_res[7]) |
                       (~instr.rd_val[7] & cmp_sub[7] & cmp_res[7]);
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      cnt_q   <= CYC_ONE;
      set_i_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (accept && (cycles_d != CYC_ONE)) begin
            state_q <= ST_EXEC;
            cnt_q   <= cycles_d - CYC_ONE; // RULE13
            set_i_q <= set_i_d;
          end
        end
        ST_EXEC: begin
          if (finish) begin
            state_q <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q - CYC_ONE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Target capture, stack traffic and retire
  // ****************************************************************
  // The popped return address is valid only in the cycle after the pop
  // request, so it is captured exactly then.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      target_q <= PC_RST;
    end else if (accept) begin
      target_q <= target_d;
    end else if (pop_wait_q) begin
      target_q <= stack_pop_data; // RULE12
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      push_q     <= '0;
      pop_q      <= 1'b0;
      pop_wait_q <= 1'b0;
    end else begin
      push_q.stb <= accept && push_d; // RULE12
      if (accept && push_d) begin
        push_q.data <= ret_addr_d;
      end
      pop_q      <= accept && pop_d;
      pop_wait_q <= pop_q;
    end
  end

  // Retire is raised in the same cycle that the program counter first shows its new value.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      retire_q <= 1'b0;
    end else begin
      retire_q <= (accept && (cycles_d == CYC_ONE)) || finish;
    end
  end

  // ****************************************************************
  // Program counter and status register
  // ****************************************************************
  // Hardware updates win over a software write in the same cycle.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pc_q <= PC_RST;
    end else if (accept && (cycles_d == CYC_ONE)) begin
      pc_q <= target_d; // RULE2
    end else if (finish) begin
      pc_q <= target_q; // RULE1
    end else if (bus_we && (bus_addr == ADDR_PC)) begin
      pc_q <= bus_wdata[PC_W-1:0];
    end
  end

  // A compare and an exit never finish together, as exits keep us busy.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      status_register_q <= STATUS_RST;
    end else if (accept && cmp_en) begin
      status_register_q <= status_register_d; // RULE3
    end else if (finish && set_i_q) begin
      status_register_q[FLAG_I] <= 1'b1; // RULE12
    end else if (bus_we && (bus_addr == ADDR_STATUS)) begin
      status_register_q <= bus_wdata[DATA_W-1:0];
    end
  end

  // ****************************************************************
  // Register port
  // ****************************************************************
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      run_q <= CTRL_RUN_RST;
    end else if (bus_we && (bus_addr == ADDR_CTRL)) begin
      run_q <= bus_wdata[CTRL_RUN_BIT];
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q <= '0;
    end else if (bus_re) begin
      case (bus_addr)
        ADDR_CTRL:   rdata_q <= {15'h0000, run_q};
        ADDR_STATUS: rdata_q <= {8'h00, status_register_q};
        ADDR_PC:     rdata_q <= pc_q;
        default:     rdata_q <= '0;
      endcase
    end else begin
      rdata_q <= '0;
    end
  end

endmodule

// *** core/bcc_pkg.sv ***
// Shared constants, operation codes and carriers for the program-flow unit.
package bcc_pkg;

  // ****************************************************************
  // Widths and timing
  // ****************************************************************
  localparam int PC_W        = 16;
  localparam int DATA_W      = 8;
  localparam int BUS_AW      = 8;
  localparam int BUS_DW      = 16;
  localparam int CYC_W       = 3;

  localparam logic [CYC_W-1:0] CYC_ONE      = 3'h1;
  localparam logic [CYC_W-1:0] CYC_REL_CALL = 3'h3;
  localparam logic [CYC_W-1:0] CYC_IND_CALL = 3'h3;
  localparam logic [CYC_W-1:0] CYC_DIR_CALL = 3'h4;
  localparam logic [CYC_W-1:0] CYC_EXIT     = 3'h4;
  localparam logic [CYC_W-1:0] CYC_BR_TAKEN = 3'h2;
  localparam logic [CYC_W-1:0] CYC_SKIP_ONE = 3'h2;
  localparam logic [CYC_W-1:0] CYC_SKIP_TWO = 3'h3;

  // ****************************************************************
  // Register map and reset values
  // ****************************************************************
  localparam logic [BUS_AW-1:0] ADDR_CTRL   = 8'h00;
  localparam logic [BUS_AW-1:0] ADDR_STATUS = 8'h04;
  localparam logic [BUS_AW-1:0] ADDR_PC     = 8'h08;

  localparam int CTRL_RUN_BIT = 0;

  localparam logic              CTRL_RUN_RST = 1'h0;
  localparam logic [DATA_W-1:0] STATUS_RST   = 8'h00;
  localparam logic [PC_W-1:0]   PC_RST       = 16'h0000;

  // ****************************************************************
  // Status register bit positions
  // ****************************************************************
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // ****************************************************************
  // Operations and instruction carrier
  // ****************************************************************
  typedef enum logic [4:0] {
    OP_RELATIVE_SUBROUTINE_JUMP,
    OP_INDIRECT_SUBROUTINE_JUMP,
    OP_DIRECT_SUBROUTINE_JUMP,
    OP_SUBROUTINE_EXIT,
    OP_INTERRUPT_EXIT,
    OP_COMPARE_SKIP_EQUAL,
    OP_REGISTER_COMPARE,
    OP_COMPARE_WITH_CARRY,
    OP_COMPARE_IMMEDIATE,
    OP_SKIP_IF_REGISTER_BIT_CLEAR,
    OP_SKIP_IF_REGISTER_BIT_SET,
    OP_SKIP_IF_IO_BIT_CLEAR,
    OP_SKIP_IF_IO_BIT_SET,
    OP_BRANCH_ON_FLAG_SET,
    OP_BRANCH_ON_FLAG_CLEAR,
    OP_BRANCH_ON_EQUAL,
    OP_BRANCH_ON_NOT_EQUAL,
    OP_SEQUENTIAL
  } bcc_op_e;

  typedef struct packed {
    bcc_op_e           op;
    logic [DATA_W-1:0] rd_val;
    logic [DATA_W-1:0] rr_val;
    logic [DATA_W-1:0] imm_val;
    logic [DATA_W-1:0] io_val;
    logic [2:0]        bit_sel;
    logic [PC_W-1:0]   k_val;
    logic [PC_W-1:0]   z_ptr;
    logic              next_two_words;
  } bcc_instr_s;

  typedef struct packed {
    logic              stb;
    logic [PC_W-1:0]   data;
  } bcc_stack_s;

endpackage

// *** testbench/bcc_flow_unit_assertions.sv ***
// Port assertions for the program-flow unit.
`timescale 1ns/10ps
module bcc_flow_unit_checker (
  input wire logic                      clock,
  input wire logic                      sys_rst,
  input wire bcc_pkg::bcc_instr_s       instr,
  input wire logic                      instr_valid,
  input wire logic                      instr_ready,
  input wire logic                      retire,
  input wire logic [bcc_pkg::PC_W-1:0]  pc,
  input wire logic [7:0]                status_flags,
  input wire bcc_pkg::bcc_stack_s       stack_push,
  input wire logic                      stack_pop
);
  import bcc_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic acc;
  assign acc = instr_valid && instr_ready;

  property p_rel_call;
    acc && instr.op == OP_RELATIVE_SUBROUTINE_JUMP |=>
      !retire ##1 !retire ##1 retire;
  endproperty
  a_rel_call: assert property (p_rel_call)
    else $error("relative call did not retire in three cycles");
  property p_dir_call;
    acc && instr.op == OP_DIRECT_SUBROUTINE_JUMP |=> !retire[*3] ##1 retire;
  endproperty
  a_dir_call: assert property (p_dir_call)
    else $error("direct call did not retire in four cycles");
  property p_call_push;
    acc && (instr.op == OP_RELATIVE_SUBROUTINE_JUMP ||
            instr.op == OP_INDIRECT_SUBROUTINE_JUMP) |=>
      stack_push.stb && stack_push.data == $past(pc) + 16'h0001;
  endproperty
  a_call_push: assert property (p_call_push)
    else $error("call did not push its return address");
  property p_exit;
    acc && (instr.op == OP_SUBROUTINE_EXIT ||
            instr.op == OP_INTERRUPT_EXIT) |=> stack_pop ##3 retire;
  endproperty
  a_exit: assert property (p_exit)
    else $error("exit did not pop and retire in four cycles");
  property p_int_exit;
    acc && instr.op == OP_INTERRUPT_EXIT |=> ##3 status_flags[FLAG_I];
  endproperty
  a_int_exit: assert property (p_int_exit)
    else $error("interrupt exit left interrupts disabled");
  property p_cmp;
    acc && (instr.op == OP_REGISTER_COMPARE ||
            instr.op == OP_COMPARE_WITH_CARRY ||
            instr.op == OP_COMPARE_IMMEDIATE) |=>
      retire && pc == $past(pc) + 16'h0001;
  endproperty
  a_cmp: assert property (p_cmp)
    else $error("compare did not complete in one cycle");
  property p_branch_on_equal;
    acc && instr.op == OP_BRANCH_ON_EQUAL && status_flags[FLAG_Z] |=>
      !retire ##1 retire &&
      pc == $past(pc, 2) + $past(instr.k_val, 2) + 16'h0001;
  endproperty
  a_branch_on_equal: assert property (p_branch_on_equal)
    else $error("taken equal branch went wrong");
  property p_branch_on_not_equal;
    acc && instr.op == OP_BRANCH_ON_NOT_EQUAL && status_flags[FLAG_Z] |=>
      retire && pc == $past(pc) + 16'h0001;
  endproperty
  a_branch_on_not_equal: assert property (p_branch_on_not_equal)
    else $error("untaken not-equal branch went wrong");
  property p_br_flags;
    acc && (instr.op == OP_BRANCH_ON_FLAG_SET ||
            instr.op == OP_BRANCH_ON_FLAG_CLEAR) |=>
      status_flags == $past(status_flags);
  endproperty
  a_br_flags: assert property (p_br_flags)
    else $error("flag branch changed the flags");
endmodule

bind bcc_flow_unit bcc_flow_unit_checker i_chk (.clock, .sys_rst, .instr,
  .instr_valid, .instr_ready, .retire, .pc, .status_flags, .stack_push,
  .stack_pop);

// *** testbench/tb_bcc_flow_unit.sv ***
// Self-checking bench for the program-flow unit.
`timescale 1ns/10ps
module tb_bcc_flow_unit;
  import bcc_pkg::*;
  logic        clock, sys_rst, instr_valid, instr_ready, retire;
  logic        stack_pop, bus_we, bus_re;
  bcc_instr_s  instr;
  bcc_stack_s  stack_push;
  logic [15:0] pc, stack_pop_data, bus_wdata, bus_rdata, epc, ret_val, psh;
  logic [7:0]  status_flags, bus_addr, esr, v;
  int          mismatches, comparisons, cycles;
  bcc_op_e     ops[6];

  bcc_flow_unit i_dut (.clock, .sys_rst, .instr, .instr_valid,
    .instr_ready, .retire, .pc, .status_flags, .stack_push, .stack_pop,
    .stack_pop_data, .bus_addr, .bus_wdata, .bus_we, .bus_re, .bus_rdata);

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // Popped data is valid only in the cycle after the pop request.
  always @(posedge clock) begin
    stack_pop_data <= stack_pop ? ret_val : ~ret_val;
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      mismatches++;
      print_verdict();
    end
  end

  // ********
  // Tasks
  // ********
  task automatic print_verdict();
    if (mismatches == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    bus_addr <= a;
    bus_wdata <= d;
    bus_we <= 1'b1;
    @(posedge clock);
    bus_we <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [15:0] e);
    @(posedge clock);
    bus_addr <= a;
    bus_re <= 1'b1;
    @(posedge clock);
    bus_re <= 1'b0;
    @(negedge clock);
    chk("read data", e, bus_rdata);
  endtask
  function automatic bcc_instr_s mk(bcc_op_e op, logic [7:0] a, b,
                                    logic [2:0] s, logic [15:0] k, logic t);
    mk = '0;
    mk.op = op;
    mk.rd_val = a;
    mk.io_val = a;
    mk.rr_val = b;
    mk.imm_val = b;
    mk.bit_sel = s;
    mk.k_val = k;
    mk.z_ptr = k;
    mk.next_two_words = t;
  endfunction
  function automatic logic [7:0] cmpf(logic [7:0] sr, a, b, logic c, kz);
    logic [8:0] r;
    logic [4:0] h;
    r = {1'b0, a} - {1'b0, b} - 9'(c);
    h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - 5'(c);
    cmpf = sr;
    cmpf[FLAG_C] = r[8];
    cmpf[FLAG_H] = h[4];
    cmpf[FLAG_N] = r[7];
    cmpf[FLAG_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
    cmpf[FLAG_Z] = (r[7:0] == 8'h00) && (!kz || sr[FLAG_Z]);
  endfunction
  task automatic exec(input bcc_instr_s ins, input logic [15:0] e, int en);
    int n;
    n = 0;
    @(posedge clock);
    instr <= ins;
    instr_valid <= 1'b1;
    @(negedge clock);
    while (instr_ready !== 1'b1 && n < 50) begin
      @(negedge clock);
      n++;
    end
    @(posedge clock);
    instr_valid <= 1'b0;
    n = 0;
    do begin
      @(negedge clock);
      n++;
      if (stack_push.stb === 1'b1) psh = stack_push.data;
    end while (retire !== 1'b1 && n < 20);
    chk("cycles", 16'(en), 16'(n));
    chk("pc", e, pc);
    epc = e;
  endtask

  // ********
  // Scenarios
  // ********
  task automatic t_calls_exits();
    logic [15:0] p;
    wr(ADDR_STATUS, 16'h0003);
    p = epc;
    exec(mk(OP_RELATIVE_SUBROUTINE_JUMP, 0, 0, 0, 16'hfff0, 0),
         p - 16'h000f, 3);
    chk("push", p + 16'h0001, psh);
    p = epc;
    exec(mk(OP_INDIRECT_SUBROUTINE_JUMP, 0, 0, 0, 16'h0200, 0),
         16'h0200, 3);
    chk("push", p + 16'h0001, psh);
    exec(mk(OP_DIRECT_SUBROUTINE_JUMP, 0, 0, 0, 16'h0300, 0),
         16'h0300, 4);
    chk("push", 16'h0202, psh);
    chk("flags", 16'h0003, 16'(status_flags));
    ret_val = 16'h1234;
    exec(mk(OP_SUBROUTINE_EXIT, 0, 0, 0, 0, 0), 16'h1234, 4);
    ret_val = 16'h0040;
    exec(mk(OP_INTERRUPT_EXIT, 0, 0, 0, 0, 0), 16'h0040, 4);
    chk("flags", 16'h0083, 16'(status_flags));
  endtask
  task automatic t_compares();
    logic [7:0] a[6] = '{8'h42, 8'h10, 8'h80, 8'h00, 8'h05, 8'h42};
    logic [7:0] b[6] = '{8'h42, 8'h01, 8'h01, 8'h01, 8'h04, 8'h42};
    ops = '{OP_REGISTER_COMPARE, OP_REGISTER_COMPARE, OP_REGISTER_COMPARE,
            OP_COMPARE_IMMEDIATE, OP_COMPARE_WITH_CARRY,
            OP_COMPARE_WITH_CARRY};
    esr = 8'h40;
    wr(ADDR_STATUS, 16'(esr));
    for (int i = 0; i < 6; i++) begin
      esr = cmpf(esr, a[i], b[i], esr[FLAG_C] && i > 3, i > 3);
      exec(mk(ops[i], a[i], b[i], 0, 0, 0), epc + 16'h0001, 1);
      chk("flags", 16'(esr), 16'(status_flags));
    end
  endtask
  task automatic t_skips();
    logic [7:0] a, b;
    ops = '{OP_COMPARE_SKIP_EQUAL, OP_SKIP_IF_REGISTER_BIT_CLEAR,
            OP_SKIP_IF_REGISTER_BIT_SET, OP_SKIP_IF_IO_BIT_CLEAR,
            OP_SKIP_IF_IO_BIT_SET, OP_SEQUENTIAL};
    for (int i = 0; i < 20; i++) begin
      v = ((i[4:2] == 3'h1 || i[4:2] == 3'h3) ^ i[1]) ? 8'h04 : 8'h00;
      a = (i < 4) ? 8'h05 : v;
      b = (i < 4) ? (i[1] ? 8'h05 : 8'h06) : v;
      exec(mk(ops[i / 4], a, b, 3'h2, 0, i[0]),
           epc + (i[1] ? 16'h0002 + 16'(i[0]) : 16'h0001),
           i[1] ? 2 + i[0] : 1);
      chk("flags", 16'(esr), 16'(status_flags));
    end
  endtask
  task automatic t_branches();
    for (int s = 0; s < 8; s++) begin
      wr(ADDR_STATUS, 16'h0001 << s);
      exec(mk(OP_BRANCH_ON_FLAG_SET, 0, 0, 3'(s), 16'h0005, 0),
           epc + 16'h0006, 2);
      exec(mk(OP_BRANCH_ON_FLAG_CLEAR, 0, 0, 3'(s), 16'h0005, 0),
           epc + 16'h0001, 1);
      exec(mk(OP_BRANCH_ON_FLAG_CLEAR, 0, 0, 3'(s + 1), 16'hfffe, 0),
           epc - 16'h0001, 2);
      exec(mk(OP_BRANCH_ON_FLAG_SET, 0, 0, 3'(s + 1), 16'h0005, 0),
           epc + 16'h0001, 1);
      chk("flags", 16'h0001 << s, 16'(status_flags));
    end
    for (int z = 0; z < 2; z++) begin
      wr(ADDR_STATUS, z ? 16'h0002 : 16'h0000);
      exec(mk(OP_BRANCH_ON_EQUAL, 0, 0, 0, 16'h0010, 0),
           epc + (z ? 16'h0011 : 16'h0001), z ? 2 : 1);
      exec(mk(OP_BRANCH_ON_NOT_EQUAL, 0, 0, 0, 16'h0010, 0),
           epc + (z ? 16'h0001 : 16'h0011), z ? 1 : 2);
    end
  endtask

  initial begin
    sys_rst = 1'b1;
    instr = '0;
    instr_valid = 1'b0;
    bus_addr = 8'h00;
    bus_wdata = 16'h0000;
    bus_we = 1'b0;
    bus_re = 1'b0;
    ret_val = 16'h0000;
    psh = 16'h0000;
    mismatches = 0;
    comparisons = 0;
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    rdc(ADDR_CTRL, 16'h0000);
    rdc(8'hf0, 16'h0000);
    chk("ready", 16'h0000, 16'(instr_ready));
    wr(ADDR_CTRL, 16'h0001);
    wr(ADDR_PC, 16'h0100);
    rdc(ADDR_PC, 16'h0100);
    epc = 16'h0100;
    t_calls_exits();
    t_compares();
    t_skips();
    t_branches();
    print_verdict();
  end
endmodule
